// ### inc/sto_pkg.sv
package sto_pkg;
	// register byte offsets on the slave port
	localparam logic [7:0]  OFS_DIVISOR   = 8'h00;
	localparam logic [7:0]  OFS_PROTOCOL  = 8'h04;
	localparam logic [7:0]  OFS_CONTROL   = 8'h08;
	localparam logic [7:0]  OFS_PORT_EN   = 8'h0c;
	localparam logic [7:0]  OFS_SYNC_CTRL = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	localparam int unsigned STIM_SEL_BIT  = 7;      // 0x80..0xfc: stimulus ports
	// field layout
	localparam int unsigned PRESC_W       = 13;
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned SYNC_PER_BIT  = 0;
	localparam int unsigned SYNC_REQ_BIT  = 1;
	localparam int unsigned TS_REQ_BIT    = 2;
	// reset values
	localparam logic [12:0] RST_PRESC     = 13'h0000;
	localparam logic [1:0]  PROTO_MANCH   = 2'h1;
	localparam logic [1:0]  PROTO_UART    = 2'h2;
	localparam logic [1:0]  RST_PROTO     = PROTO_MANCH;
	localparam logic [1:0]  RST_IF_SEL    = 2'h0;
	localparam logic [1:0]  IF_SEL_SWD    = 2'h1;   // latch code routing the pin
	// packet shapes
	localparam logic [2:0]  HDR_STIM_4B   = 3'h3;   // low header bits: 4-byte payload
	localparam logic [7:0]  HDR_TS        = 8'hc0;
	localparam logic [47:0] SYNC_PKT      = 48'h8000_0000_0000;
	localparam logic [2:0]  NB_STIM       = 3'h5;
	localparam logic [2:0]  NB_SYNC       = 3'h6;
	localparam logic [2:0]  NB_TS         = 3'h5;
	localparam logic [3:0]  SYNC_EVERY    = 4'hf;   // count at which auto sync is due: every 16th stimulus packet
	localparam logic [2:0]  LAST_BIT      = 3'h7;
	localparam int unsigned BUF_W         = 37;     // port number plus word
	// serializer states
	typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} sto_ser_t;
endpackage : sto_pkg

// ### design/sto_sync3.sv
`timescale 1ns/1ns
module sto_sync3 #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_stable
);
	// three stages plus the accepted value
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} sto_sync_t;

	sto_sync_t r;       // registered state
	sto_sync_t next_r;  // next state

	////////////////////////////////////////////////////////////////
	// s1 feeds s2 only; a change counts once s2 and s3 agree
	always_comb begin
		next_r    = r;
		next_r.s1 = i_async;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3) begin
			next_r.stable = r.s3;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			r.s1     <= RST_VAL;
			r.s2     <= RST_VAL;
			r.s3     <= RST_VAL;
			r.stable <= RST_VAL;
		end else begin
			r <= next_r;
		end
	end

	assign o_stable = r.stable;
endmodule : sto_sync3

// ### design/sto_buf2.sv
`timescale 1ns/1ns
module sto_buf2 #(
	parameter int unsigned W = 8
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);
	// two slots, pointers and fill level
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wptr;
		logic              rptr;
		logic [1:0]        cnt;
	} sto_buf_t;

	sto_buf_t r;       // registered state
	sto_buf_t next_r;  // next state
	logic     push;    // word taken in
	logic     pop;     // word handed out

	assign o_in_ready  = (r.cnt != 2'h2);
	assign o_out_valid = (r.cnt != 2'h0);
	assign o_out_data  = r.mem[r.rptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = i_out_ready && o_out_valid;

	////////////////////////////////////////////////////////////////
	// a full buffer drops ready, so the source must stall
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wptr] = i_in_data;
			next_r.wptr        = ~r.wptr;
		end
		if (pop) begin
			next_r.rptr = ~r.rptr;
		end
		case ({push, pop})
			2'b10:   next_r.cnt = r.cnt + 2'h1;
			2'b01:   next_r.cnt = r.cnt - 2'h1;
			default: next_r.cnt = r.cnt;
		endcase
	end

	// state register
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : sto_buf2

// ### design/sto_trace.sv
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
// Summary of operation
// - tick is bus clock over prescaler+1; a UART bit takes one tick, a Manchester bit two
// - protocol code 01 Manchester, 10 UART
// - control bit zero gates all packet output
// - per-port enable bits gate stimulus writes
// - stimulus word queued, sent as packet
// - one pin, whole bytes only
// - Manchester burst: start, bytes, stop
// - Manchester 0=01, 1=10, idle low
// - start symbol is one, stop drives low
// - UART frame: start 0, 8 bits, stop 1
// - pin driven only in serial-wire latch mode
// - no pin output in boundary-scan mode
// - firmware can send sync and time stamps
module sto_trace import sto_pkg::*; (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [1:0]  i_if_select,
	output logic             o_trace_serial_out,
	output logic             o_trace_serial_oe_n
);
	////////////////////////////////////////////////////////////////
	// all state of the block
	typedef struct packed {
		logic [12:0] divisor;    // prescaler field
		logic [1:0]  proto;      // pin protocol code
		logic        ctrl_en;    // module enable
		logic [31:0] port_en;    // stimulus port enables
		logic        sync_per;   // periodic sync on
		logic        sync_pend;  // sync packet waiting
		logic        ts_pend;    // time stamp waiting
		logic [3:0]  sync_cnt;   // stimulus packets since last sync
		logic [31:0] ts_count;   // free running stamp
		logic        avs_wait;   // waitrequest
		logic [31:0] rdata;      // read data
		logic [12:0] presc_cnt;  // divider count
		logic        tick;       // divided clock enable
		sto_ser_t    ser;        // serializer state
		logic        cur_uart;   // protocol held per packet
		logic        half;       // second half of a bit
		logic [2:0]  bitcnt;     // bit within byte
		logic [2:0]  nbyte;      // bytes still to send
		logic [47:0] shreg;      // packet bytes, lsb out
		logic        line;       // encoded line level
		logic        pin_out;    // pin output
		logic        pin_oe_n;   // pin enable, low drives
	} sto_state_t;

	sto_state_t r;       // registered state
	sto_state_t next_r;  // next state

	////////////////////////////////////////////////////////////////
	// interface-select latch, from outside the clock domain
	logic [1:0] if_sel;  // filtered latch code

	sto_sync3 #(
		.W       (2),
		.RST_VAL (RST_IF_SEL)
	) u_if_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   (i_if_select),
		.o_stable  (if_sel)
	);

	////////////////////////////////////////////////////////////////
	// stimulus queue between bus and serializer
	logic                buf_in_valid;   // bus push
	logic                buf_in_ready;   // room for a word
	logic [BUF_W-1:0]    buf_in_data;    // port and word
	logic                buf_out_valid;  // word waiting
	logic                buf_out_ready;  // serializer takes it
	logic [BUF_W-1:0]    buf_out_data;   // oldest word

	sto_buf2 #(
		.W (BUF_W)
	) u_stim_buf (
		.i_ref_clk   (i_ref_clk),
		.i_rst       (i_rst),
		.i_in_valid  (buf_in_valid),
		.o_in_ready  (buf_in_ready),
		.i_in_data   (buf_in_data),
		.o_out_valid (buf_out_valid),
		.i_out_ready (buf_out_ready),
		.o_out_data  (buf_out_data)
	);

	////////////////////////////////////////////////////////////////
	// bus decode helpers
	logic        req;       // any access present
	logic        hit_stim;  // stimulus port window
	logic [4:0]  stim_port; // port number
	logic        stim_ok;   // write will be queued
	logic [31:0] be_mask;   // byte lane mask
	logic        swd_mode;  // pin routed to trace

	assign req       = i_avs_read || i_avs_write;
	assign hit_stim  = i_avs_address[STIM_SEL_BIT] && (i_avs_address[1:0] == 2'h0);
	assign stim_port = i_avs_address[6:2];
	assign stim_ok   = r.ctrl_en && r.port_en[stim_port];
	assign be_mask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
	                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign swd_mode  = (if_sel == IF_SEL_SWD);

	// push on the completing edge of an accepted stimulus write
	assign buf_in_valid = !r.avs_wait && i_avs_write && hit_stim && stim_ok;
	assign buf_in_data  = {stim_port, i_avs_writedata};

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [31:0] rd_mux;  // current value at the address
		logic [31:0] merged;  // value after byte lanes applied
		logic        proto_ok; // protocol code usable
		logic        go;       // a packet starts
		rd_mux   = 32'h0000_0000;
		merged   = 32'h0000_0000;
		proto_ok = 1'b0;
		go       = 1'b0;
		next_r   = r;
		buf_out_ready = 1'b0;
		next_r.tick   = 1'b0;

		// divider: one tick every divisor+1 cycles
		if (r.presc_cnt >= r.divisor) begin
			next_r.presc_cnt = '0;
			next_r.tick      = 1'b1;
		end else begin
			next_r.presc_cnt = r.presc_cnt + 13'h0001;
		end
		next_r.ts_count = r.ts_count + 32'h0000_0001;

		// reserved protocol codes send nothing
		proto_ok = (r.proto == PROTO_MANCH) || (r.proto == PROTO_UART);

		//////////////////////////////////////////////////////////
		// serializer, advances only on the divided tick
		case (r.ser)
			SER_IDLE: begin
				// idle level: low for Manchester, high for UART
				next_r.line = (r.proto == PROTO_UART);
				if (r.tick && r.ctrl_en && proto_ok) begin
					// sync first, then stamp, then queued words
					if (r.sync_pend) begin
						go               = 1'b1;
						next_r.sync_pend = 1'b0;
						next_r.sync_cnt  = 4'h0;
						next_r.shreg     = SYNC_PKT;
						next_r.nbyte     = NB_SYNC;
					end else if (r.ts_pend) begin
						go             = 1'b1;
						next_r.ts_pend = 1'b0;
						next_r.shreg   = {8'h00, r.ts_count, HDR_TS};
						next_r.nbyte   = NB_TS;
					end else if (buf_out_valid) begin
						go            = 1'b1;
						buf_out_ready = 1'b1;
						// header carries the port, then the word
						next_r.shreg  = {8'h00, buf_out_data[31:0],
						                 buf_out_data[36:32], HDR_STIM_4B};
						next_r.nbyte  = NB_STIM;
						next_r.sync_cnt = r.sync_cnt + 4'h1;
						if (r.sync_per && (r.sync_cnt == SYNC_EVERY)) begin
							next_r.sync_pend = 1'b1;
						end
					end
				end
				if (go) begin
					// protocol is frozen for the whole packet
					next_r.ser      = SER_START;
					next_r.cur_uart = (r.proto == PROTO_UART);
					// Manchester start opens high, UART start is low
					next_r.line     = (r.proto != PROTO_UART);
					next_r.half     = 1'b0;
					next_r.bitcnt   = 3'h0;
				end
			end
			SER_START: begin
				if (r.tick) begin
					if (!r.cur_uart && !r.half) begin
						// second half of the start symbol
						next_r.line = 1'b0;
						next_r.half = 1'b1;
					end else begin
						next_r.ser  = SER_DATA;
						next_r.line = r.shreg[0];
						next_r.half = 1'b0;
					end
				end
			end
			SER_DATA: begin
				if (r.tick) begin
					if (!r.cur_uart && !r.half) begin
						// mid-bit transition: 1 goes 10, 0 goes 01
						next_r.line = ~r.shreg[0];
						next_r.half = 1'b1;
					end else begin
						next_r.half   = 1'b0;
						next_r.shreg  = r.shreg >> 1;
						next_r.bitcnt = r.bitcnt + 3'h1;
						next_r.line   = r.shreg[1];
						if (r.bitcnt == LAST_BIT) begin
							// byte ends: UART frames every byte
							next_r.nbyte = r.nbyte - 3'h1;
							if (r.cur_uart || (r.nbyte == 3'h1)) begin
								next_r.ser  = SER_STOP;
								next_r.line = r.cur_uart;
							end
						end
					end
				end
			end
			SER_STOP: begin
				if (r.tick) begin
					if (!r.cur_uart && !r.half) begin
						// stop holds low a full bit period
						next_r.half = 1'b1;
					end else if (r.cur_uart && (r.nbyte != 3'h0)) begin
						// next UART frame follows directly
						next_r.ser  = SER_START;
						next_r.line = 1'b0;
					end else begin
						next_r.ser = SER_IDLE;
					end
				end
			end
			default: begin
				next_r.ser = SER_IDLE;
			end
		endcase

		//////////////////////////////////////////////////////////
		// pin: driven only in serial-wire latch mode
		next_r.pin_oe_n = !swd_mode;
		next_r.pin_out  = swd_mode && r.line;

		//////////////////////////////////////////////////////////
		// read mux, also the base for byte-lane merges
		case (i_avs_address)
			OFS_DIVISOR:   rd_mux = {19'h0, r.divisor};
			OFS_PROTOCOL:  rd_mux = {30'h0, r.proto};
			OFS_CONTROL:   rd_mux = {31'h0, r.ctrl_en};
			OFS_PORT_EN:   rd_mux = r.port_en;
			OFS_SYNC_CTRL: rd_mux = {29'h0, r.ts_pend, r.sync_pend, r.sync_per};
			OFS_STATUS:    rd_mux = {28'h0, swd_mode, !buf_in_ready,
			                         buf_out_valid, (r.ser != SER_IDLE)};
			default: begin
				// stimulus read shows room in the queue
				rd_mux = hit_stim ? {31'h0, buf_in_ready} : 32'h0000_0000;
			end
		endcase
		merged = (rd_mux & ~be_mask) | (i_avs_writedata & be_mask);

		//////////////////////////////////////////////////////////
		// slave: wait high by default, one low cycle completes
		if (r.avs_wait) begin
			// a queued write to a full buffer keeps waiting
			if (req && !(i_avs_write && hit_stim && stim_ok && !buf_in_ready)) begin
				next_r.avs_wait = 1'b0;
				next_r.rdata    = i_avs_read ? rd_mux : r.rdata; // writes leave read data
			end
		end else begin
			next_r.avs_wait = 1'b1;
			if (i_avs_write) begin
				// writes take effect on the completing edge
				case (i_avs_address)
					OFS_DIVISOR:   next_r.divisor = merged[PRESC_W-1:0];
					OFS_PROTOCOL:  next_r.proto   = merged[1:0];
					OFS_CONTROL:   next_r.ctrl_en = merged[CTRL_EN_BIT];
					OFS_PORT_EN:   next_r.port_en = merged;
					OFS_SYNC_CTRL: begin
						next_r.sync_per = merged[SYNC_PER_BIT];
						// request bits only set; a same-cycle take loses
						if (i_avs_writedata[SYNC_REQ_BIT] && i_avs_byteenable[0]) begin
							next_r.sync_pend = 1'b1;
						end
						if (i_avs_writedata[TS_REQ_BIT] && i_avs_byteenable[0]) begin
							next_r.ts_pend = 1'b1;
						end
					end
					default: begin
						// status, stimulus and holes store nothing here
						next_r.rdata = r.rdata;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// state register, constants only under reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			r          <= '0;
			r.divisor  <= RST_PRESC;
			r.proto    <= RST_PROTO;
			r.avs_wait <= 1'b1;
			r.ser      <= SER_IDLE;
			r.pin_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign o_avs_readdata      = r.rdata;
	assign o_avs_waitrequest   = r.avs_wait;
	assign o_trace_serial_out  = r.pin_out;
	assign o_trace_serial_oe_n = r.pin_oe_n;
endmodule : sto_trace

// ### testbench/sto_trace_checker.sv
`timescale 1ns/1ns
// watches bus and pin ports of the trace block
module sto_trace_checker import sto_pkg::*; (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0]  i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic [1:0]  i_if_select,
	input wire logic        o_trace_serial_out,
	input wire logic        o_trace_serial_oe_n
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	logic rd_done;  // read answered this cycle
	logic cfg_req;  // request that never waits on queue room
	assign rd_done = i_avs_read && !o_avs_waitrequest;
	assign cfg_req = (i_avs_read || i_avs_write) && !(i_avs_write && i_avs_address[7]);
	////////////////////////////////////////////////////////////////////////////
	a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_answer_next: assert property (cfg_req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("register access not answered next cycle");
	a_no_idle_answer: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
		else $error("answer without a request");
	a_readdata_hold: assert property (!(i_avs_read && o_avs_waitrequest)
		|=> $stable(o_avs_readdata))
		else $error("read data moved without a read");
	a_divisor_width: assert property (rd_done && i_avs_address == OFS_DIVISOR
		|-> o_avs_readdata[31:13] == 19'h0)
		else $error("divisor reads beyond 13 bits");
	a_proto_width: assert property (rd_done && i_avs_address == OFS_PROTOCOL
		|-> o_avs_readdata[31:2] == 30'h0)
		else $error("protocol reads beyond 2 bits");
	a_enable_width: assert property (rd_done && i_avs_address == OFS_CONTROL
		|-> o_avs_readdata[31:1] == 31'h0)
		else $error("control reads beyond bit 0");
	a_pin_release: assert property ((i_if_select != IF_SEL_SWD) [*6] |=> o_trace_serial_oe_n)
		else $error("pin driven outside serial-wire mode");
	a_pin_routed: assert property ((i_if_select == IF_SEL_SWD) [*6] |=> !o_trace_serial_oe_n)
		else $error("pin not driven in serial-wire mode");
	a_pin_quiet: assert property (o_trace_serial_oe_n |-> !o_trace_serial_out)
		else $error("pin data moves while not routed");
endmodule : sto_trace_checker
bind sto_trace sto_trace_checker i_sto_trace_checker (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_if_select(i_if_select), .o_trace_serial_out(o_trace_serial_out),
	.o_trace_serial_oe_n(o_trace_serial_oe_n));

// ### testbench/sto_capture.sv
`timescale 1ns/1ns
// capture device: decodes the trace pin into bytes, sampling mid-tick
module sto_capture (
	input  wire logic       i_ref_clk,
	input  wire logic       i_pin,
	input  wire logic [1:0] i_proto,  // 01 manchester, 10 uart
	input  wire logic [7:0] i_ticks,  // clocks per tick, at least 2
	output logic      [7:0] o_byte,
	output int              o_count   // bytes decoded so far
);
	logic [7:0] sr;  // shift register, lsb arrives first
	logic       a;   // first half of a symbol
	logic       b;   // second half
	int         n;   // bits in this burst
	////////////////////////////////////////////////////////////////////////////
	// protocol is rechecked after each edge: a mode switch also moves the idle level
	initial begin
		o_byte = 8'h00;
		o_count = 0;
		forever begin
			if (i_proto == 2'h2) begin
				@(negedge i_pin);  // align on the start bit
				repeat (i_ticks / 2) @(posedge i_ref_clk);
				if (i_proto == 2'h2 && i_pin == 1'b0) begin
					for (n = 0; n < 8; n++) begin
						repeat (i_ticks) @(posedge i_ref_clk);
						sr = {i_pin, sr[7:1]};
					end
					repeat (i_ticks) @(posedge i_ref_clk);
					o_byte = (i_pin === 1'b1) ? sr : ~sr;  // bad stop spoils the byte
					o_count++;
				end
			end else begin
				@(posedge i_pin);
				repeat (i_ticks / 2) @(posedge i_ref_clk);
				a = i_pin;
				repeat (i_ticks) @(posedge i_ref_clk);
				if (i_proto == 2'h1 && a && !i_pin) begin
					n = 0;
					forever begin
						repeat (i_ticks) @(posedge i_ref_clk);
						a = i_pin;
						repeat (i_ticks) @(posedge i_ref_clk);
						b = i_pin;
						if (!a && !b) break;  // low-low ends the burst
						sr = {(a != b) ? a : ~a, sr[7:1]};  // bad symbol flips the bit
						n++;
						if (n % 8 == 0) begin
							o_byte = sr;
							o_count++;
						end
					end
				end
			end
		end
	end
endmodule : sto_capture

// ### testbench/sto_trace_test.sv
`timescale 1ns/1ns
module sto_trace_test import sto_pkg::*; ;
	logic        ref_clk;
	logic        rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [1:0]  if_select;
	logic        pin_out;
	logic        pin_oe_n;
	logic [1:0]  proto;      // mode the capture side decodes
	logic [7:0]  ticks;      // clocks per tick, divisor plus one
	logic [7:0]  rx_byte;
	int          rx_count;
	logic [7:0]  rxq[$];     // bytes seen on the pin
	logic [7:0]  expq[$];    // bytes expected
	logic [31:0] lfsr;
	logic [31:0] rd;
	logic [31:0] pe;         // port enable pattern
	int          err_count;
	int          checked;
	logic [7:0]  ofs [6] = '{OFS_DIVISOR, OFS_PROTOCOL, OFS_CONTROL, OFS_PORT_EN, OFS_SYNC_CTRL,
		8'h40};
	logic [31:0] rw_mask [4] = '{32'h1fff, 32'h3, 32'h1, 32'hffff_ffff};
	sto_trace i_sto_trace (.i_ref_clk(ref_clk), .i_rst(rst), .i_avs_address(address),
		.i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
		.i_if_select(if_select), .o_trace_serial_out(pin_out), .o_trace_serial_oe_n(pin_oe_n));
	sto_capture i_sto_capture (.i_ref_clk(ref_clk), .i_pin(pin_out), .i_proto(proto),
		.i_ticks(ticks), .o_byte(rx_byte), .o_count(rx_count));
	////////////////////////////////////////////////////////////////////////////
	// clock, 50 ns period
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// collect every decoded byte
	always @(rx_count) begin
		if (rx_count != 0) rxq.push_back(rx_byte);
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task tally_and_finish;
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// one bus transfer, held until waitrequest is seen low
	task bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		read <= !we;
		write <= we;
		address <= a;
		writedata <= wd;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 2000);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 2000) begin
			err_count++;
			tally_and_finish();
		end
	endtask : bus
	// back-to-back stimulus writes; a full queue stalls the bus, nothing is lost
	task run_pass(input logic on);
		logic [4:0] p;
		for (int k = 0; k < 6; k++) begin
			lfsr = lfsr_next(lfsr);
			p = (k == 0) ? 5'd1 : (k == 1) ? 5'd31 : lfsr[4:0];
			bus(1'b1, 8'h80 + {1'b0, p, 2'b00}, lfsr);
			if (on && pe[p]) begin
				expq.push_back({p, HDR_STIM_4B});
				for (int i = 0; i < 4; i++) expq.push_back(lfsr[8*i +: 8]);
			end
		end
	endtask : run_pass
	// wait until the serializer and queue are idle, then compare the bytes
	task drain(input logic idle_level);
		int n;
		n = 0;
		// a pending sync or stamp starts only at the next tick, so let two pass first
		repeat (2 * ticks) @(posedge ref_clk);
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b00 && n < 5000);
		if (n >= 5000) begin
			err_count++;
			tally_and_finish();
		end
		repeat (4 * ticks) @(posedge ref_clk);
		check("byte count", rxq.size(), expq.size());
		foreach (expq[i]) begin
			if (i < rxq.size()) check("byte", rxq[i], expq[i]);
		end
		check("idle level", pin_out, idle_level);
		rxq = {};
		expq = {};
	endtask : drain
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		if_select = 2'h0;
		proto = PROTO_MANCH;
		ticks = 8'd4;
		lfsr = 32'h0917;
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		if_select <= IF_SEL_SWD;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			check("reset value", rd, (i == 1) ? 32'h1 : 32'h0);
		end
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ofs[i], 32'hffff_ffff);
			bus(1'b0, ofs[i], 32'h0);
			check("field width", rd, rw_mask[i]);
		end
		// manchester at four clocks per tick
		lfsr = lfsr_next(lfsr);
		pe = (lfsr | 32'h8000_0001) & ~32'h2;
		bus(1'b1, OFS_PROTOCOL, {30'h0, PROTO_MANCH});
		bus(1'b1, OFS_DIVISOR, 32'h3);
		bus(1'b1, OFS_PORT_EN, pe);
		run_pass(1'b1);
		drain(1'b0);
		// module disabled: writes dropped
		bus(1'b1, OFS_CONTROL, 32'h0);
		run_pass(1'b0);
		drain(1'b0);
		// firmware sync request
		bus(1'b1, OFS_CONTROL, 32'h1);
		bus(1'b1, OFS_SYNC_CTRL, 32'h2);
		repeat (5) expq.push_back(8'h00);
		expq.push_back(8'h80);
		drain(1'b0);
		// uart at seven clocks per tick
		proto = PROTO_UART;
		ticks = 8'd7;
		bus(1'b1, OFS_DIVISOR, 32'h6);
		bus(1'b1, OFS_PROTOCOL, {30'h0, PROTO_UART});
		repeat (40) @(posedge ref_clk);
		run_pass(1'b1);
		drain(1'b1);
		// leave serial-wire mode: pin released
		if_select <= 2'h2;
		repeat (8) @(posedge ref_clk);
		check("pin released", pin_oe_n, 1'b1);
		tally_and_finish();
	end
endmodule : sto_trace_test
